// ### dv/packed_saturating_add_and_unit_tb.sv
`timescale 1ns/1ns

module packed_saturating_add_and_unit_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    wire  [7:0]  paddr;
    wire  [31:0] pwdata, prdata;
    wire         psel, penable, pwrite, pready, pslverr;
    int          err_count, samples_checked, b;
    int          seed = 32'hd850;
    logic [31:0] v, fm;
    logic [63:0] dv, sv, got;
    logic [15:0] op;
    logic [2:0]  dr, sr;
    logic        m, e;
    logic [15:0] ops [5] = '{16'h0fec, 16'h0fed, 16'h0fdc, 16'h0fdd, 16'h0fdb};
    logic [31:0] fc [9] = '{1, 2, 4, 8, 8, 8, 56, 0, 0};
    logic [31:0] fk [9] = '{0, 0, 0, 1, 2, 32'h0005_0004, 0, 0, 0};
    logic [31:0] fa [9] = '{0, 0, 0, 0, 0, 0, 1, 32'hfff9, 32'hfff8};
    int          fb [9] = '{1, 2, 3, 4, 5, 6, 7, 8, 0};

    psau_unit dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    psau_host u_host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // 50 MHz clock
    always #10 pclk = ~pclk;

    // Lane-wise expected result
    function automatic logic [63:0] calc(logic [15:0] o, logic [63:0] d, logic [63:0] s);
        logic [63:0] r;
        int          t;
        r = d & s;
        for (int i = 0; i < 64; i += 8) begin
            if (o == 16'h0fec) begin
                t = $signed(d[i+:8]) + $signed(s[i+:8]);
                r[i+:8] = t > 127 ? 8'h7f : t < -128 ? 8'h80 : t[7:0];
            end
            if (o == 16'h0fdc) begin
                t = d[i+:8] + s[i+:8];
                r[i+:8] = t > 255 ? 8'hff : t[7:0];
            end
            if (i % 16 == 0 && o == 16'h0fed) begin
                t = $signed(d[i+:16]) + $signed(s[i+:16]);
                r[i+:16] = t > 32767 ? 16'h7fff : t < -32768 ? 16'h8000 : t[15:0];
            end
            if (i % 16 == 0 && o == 16'h0fdd) begin
                t = d[i+:16] + s[i+:16];
                r[i+:16] = t > 65535 ? 16'hffff : t[15:0];
            end
        end
        return r;
    endfunction

    // Compare and count
    task automatic chk(string n, logic [63:0] g, logic [63:0] x);
        samples_checked++;
        if (g !== x) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask

    // Register access helpers
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] r;
        logic        q;
        u_host.xfer(1'b1, a, d, r, q);
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] r);
        logic q;
        u_host.xfer(1'b0, a, 32'h0, r, q);
    endtask
    task automatic wr64(logic [2:0] i, logic [63:0] d);
        wr({2'b01, i, 3'b000}, d[31:0]);
        wr({2'b01, i, 3'b100}, d[63:32]);
    endtask
    task automatic rd64(logic [2:0] i, output logic [63:0] d);
        rd({2'b01, i, 3'b000}, d[31:0]);
        rd({2'b01, i, 3'b100}, d[63:32]);
    endtask
    task automatic run(logic [15:0] o, logic [2:0] d, logic [2:0] s, logic mm);
        psau_pkg::psau_cmd_t c;
        c = '0;
        {c.start, c.src_mem, c.src, c.dst, c.opcode} = {1'b1, mm, s, d, o};
        wr(psau_pkg::OFS_CMD, c);
    endtask

    // Verdict
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #200_000;
        err_count++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(psau_pkg::OFS_FAULT, v);
        chk("fault_reset", v, 0);
        rd64(3'h7, got);
        chk("preg_reset", got, 0);
        u_host.xfer(1'b0, 8'h1c, 32'h0, v, e);
        chk("unmapped", {e, v}, 64'h1_0000_0000);
        for (int i = 0; i < 30; i++) begin
            op = ops[i % 5];
            dv = {$random(seed), $random(seed)};
            sv = {$random(seed), $random(seed)};
            {m, dr, sr} = 7'($random(seed));
            if (i < 5) begin
                dv = 64'h7f7f_8080_ffff_8000;
                sv = 64'h0101_8080_0101_8000;
            end
            // Full low byte lane beside an empty one, unsigned byte form
            if (i == 7) begin
                dv[15:0] = 16'h00ff;
                sv[15:0] = 16'h00ff;
            end
            if (!m && sr == dr) sv = dv;
            wr64(dr, dv);
            if (m) begin
                wr(psau_pkg::OFS_MLO, sv[31:0]);
                wr(psau_pkg::OFS_MHI, sv[63:32]);
            end else begin
                wr64(sr, sv);
            end
            run(op, dr, sr, m);
            rd(psau_pkg::OFS_FAULT, v);
            chk("commit", v, 1);
            rd64(dr, got);
            chk("result", got, calc(op, dv, sv));
            if (!m && sr != dr) begin
                rd64(sr, got);
                chk("src_kept", got, sv);
            end
        end
        rd(psau_pkg::OFS_CTRL, v);
        chk("ctrl_kept", v, 0);
        for (int k = 0; k < 9; k++) begin
            b = fb[k];
            dv = {$random(seed), $random(seed)};
            sv = {$random(seed), $random(seed)};
            wr(psau_pkg::OFS_CTRL, fc[k]);
            wr(psau_pkg::OFS_MCHK, fk[k]);
            wr(psau_pkg::OFS_MADDR, fa[k]);
            wr(psau_pkg::OFS_MLO, sv[31:0]);
            wr(psau_pkg::OFS_MHI, sv[63:32]);
            wr64(3'h2, dv);
            run(16'h0fdb, 3'h2, 3'h0, 1'b1);
            rd(psau_pkg::OFS_FAULT, v);
            fm = (b == 5 || b == 7 || b == 8) ? 32'hffff : 32'hffff_ffff;
            chk("fault", v & fm, (1 << b) | (b == 6 ? 32'h0005_0000 : 0));
            rd64(3'h2, got);
            chk("fault_dst", got, b ? dv : dv & sv);
        end
        summarize();
    end
endmodule

// ### dv/psau_host.sv
`timescale 1ns/1ns

module psau_host (
    // Bus clock
    input  wire logic        pclk,
    // Request side
    output logic      [7:0]  paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] pwdata,
    // Answer side
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // Idle bus at time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end

    // One transfer: setup, access until ready, then one idle edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;  // Released data no longer holds the old value
        @(posedge pclk);
    endtask
endmodule

// ### rtl/psau_pkg.sv
package psau_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_CMD    = 8'h04;
    localparam logic [7:0]  OFS_MADDR  = 8'h08;
    localparam logic [7:0]  OFS_MCHK   = 8'h0c;
    localparam logic [7:0]  OFS_MLO    = 8'h10;
    localparam logic [7:0]  OFS_MHI    = 8'h14;
    localparam logic [7:0]  OFS_FAULT  = 8'h18;
    localparam logic [1:0]  FILE_PAGE  = 2'h1;      // paddr[7:6] of the packed registers
    localparam int          FILE_IDX_LSB = 3;       // paddr[5:3] picks the register
    localparam int          FILE_HALF_BIT = 2;      // paddr[2] picks the upper word
    localparam int          NUM_PREGS  = 8;

    // ------------------------------------------------------------
    // Opcodes (two bytes, escape byte first)
    // ------------------------------------------------------------
    localparam logic [15:0] OPC_SB     = 16'h0fec;
    localparam logic [15:0] OPC_SW     = 16'h0fed;
    localparam logic [15:0] OPC_UB     = 16'h0fdc;
    localparam logic [15:0] OPC_UW     = 16'h0fdd;
    localparam logic [15:0] OPC_AND    = 16'h0fdb;

    // ------------------------------------------------------------
    // Saturation limits and fault figures
    // ------------------------------------------------------------
    localparam logic [7:0]  SB_MAX     = 8'h7f;
    localparam logic [7:0]  SB_MIN     = 8'h80;
    localparam logic [15:0] SW_MAX     = 16'h7fff;
    localparam logic [15:0] SW_MIN     = 16'h8000;
    localparam logic [7:0]  UB_MAX     = 8'hff;
    localparam logic [15:0] UW_MAX     = 16'hffff;
    localparam logic [32:0] REAL_LIMIT = 33'h0_0000_ffff;
    localparam logic [32:0] OPND_LAST  = 33'h0_0000_0007;   // last byte of a 64-bit operand
    localparam logic [1:0]  CPL_USER   = 2'h3;
    localparam logic [15:0] GP_CODE    = 16'h0000;
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;
    localparam logic [63:0] RST_PREG   = 64'h0000_0000_0000_0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_SB   = 3'b001,
        OP_SW   = 3'b010,
        OP_UB   = 3'b011,
        OP_UW   = 3'b100,
        OP_AND  = 3'b101
    } psau_op_t;

    typedef struct packed {
        logic [25:0] rsvd;
        logic [1:0]  cpl;
        logic        prot_mode;
        logic        fpu_pending;
        logic        task_switched_bit;
        logic        emulation_control_bit;
    } psau_ctrl_t;

    typedef struct packed {
        logic        start;
        logic [7:0]  rsvd;
        logic        src_mem;
        logic [2:0]  src;
        logic [2:0]  dst;
        logic [15:0] opcode;
    } psau_cmd_t;

    typedef struct packed {
        logic [15:0] pf_code;
        logic [12:0] rsvd;
        logic        page_miss;
        logic        stack_bad;
        logic        seg_bad;
    } psau_memchk_t;

    typedef struct packed {
        logic [15:0] code;
        logic [6:0]  rsvd;
        logic        real_range;
        logic        alignment_check_fault;
        logic        page_fault;
        logic        stack_fault;
        logic        general_protection_fault;
        logic        math_fault;
        logic        device_not_available_fault;
        logic        invalid_opcode_fault;
        logic        committed;
    } psau_fault_t;

endpackage

// ### rtl/psau_unit.sv
`timescale 1ns/1ns

module psau_unit (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    psau_pkg::psau_ctrl_t   ctrl;
    psau_pkg::psau_cmd_t    cmd;
    psau_pkg::psau_memchk_t memchk;
    psau_pkg::psau_fault_t  fault;
    psau_pkg::psau_fault_t  next_fault;
    psau_pkg::psau_op_t     op;
    logic [31:0]            mem_addr;
    logic [63:0]            mem_data;
    logic [63:0]            preg [0:psau_pkg::NUM_PREGS-1];
    logic                   exec_go;
    logic                   resp;
    logic                   bus_wr;
    logic                   hit;
    logic [31:0]            rd_val;
    logic [63:0]            dst_op;
    logic [63:0]            src_op;
    logic [63:0]            sb_res;
    logic [63:0]            sw_res;
    logic [63:0]            ub_res;
    logic [63:0]            uw_res;
    logic [63:0]            result;
    logic [32:0]            addr_end;
    logic                   any_fault;
    logic [2:0]             file_idx;

    // ------------------------------------------------------------
    // APB handshake: one wait state on every access
    // ------------------------------------------------------------

    // Wait state toggles once per access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp <= 1'b0;
        end else begin
            resp <= psel && penable && !resp;
        end
    end

    assign pready = resp;
    assign bus_wr = psel && penable && pwrite && resp;
    assign file_idx = paddr[psau_pkg::FILE_IDX_LSB +: 3];

    // Address decode and read mux
    always_comb begin
        hit = 1'b1;
        rd_val = psau_pkg::RST_WORD;
        if (paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end else if (paddr == psau_pkg::OFS_CTRL) begin
            rd_val = ctrl;
        end else if (paddr == psau_pkg::OFS_CMD) begin
            rd_val = cmd;
        end else if (paddr == psau_pkg::OFS_MADDR) begin
            rd_val = mem_addr;
        end else if (paddr == psau_pkg::OFS_MCHK) begin
            rd_val = memchk;
        end else if (paddr == psau_pkg::OFS_MLO) begin
            rd_val = mem_data[31:0];
        end else if (paddr == psau_pkg::OFS_MHI) begin
            rd_val = mem_data[63:32];
        end else if (paddr == psau_pkg::OFS_FAULT) begin
            rd_val = fault;
        end else if (paddr[7:6] == psau_pkg::FILE_PAGE) begin
            rd_val = paddr[psau_pkg::FILE_HALF_BIT] ? preg[file_idx][63:32]
                                                    : preg[file_idx][31:0];
        end else begin
            hit = 1'b0;
        end
    end

    // Read data and error latched in the wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= psau_pkg::RST_WORD;
            pslverr <= 1'b0;
        end else if (psel && penable && !resp) begin
            prdata  <= pwrite ? psau_pkg::RST_WORD : rd_val;
            pslverr <= !hit;
        end
    end

    // ------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------

    // Control, memory address, memory checks and memory data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= psau_pkg::RST_WORD;
            memchk   <= psau_pkg::RST_WORD;
            mem_addr <= psau_pkg::RST_WORD;
            mem_data <= psau_pkg::RST_PREG;
        end else if (bus_wr) begin
            if (paddr == psau_pkg::OFS_CTRL) begin
                ctrl <= {26'h0, pwdata[5:0]};
            end else if (paddr == psau_pkg::OFS_MCHK) begin
                memchk <= {pwdata[31:16], 13'h0, pwdata[2:0]};
            end else if (paddr == psau_pkg::OFS_MADDR) begin
                mem_addr <= pwdata;
            end else if (paddr == psau_pkg::OFS_MLO) begin
                mem_data[31:0] <= pwdata;
            end else if (paddr == psau_pkg::OFS_MHI) begin
                mem_data[63:32] <= pwdata;
            end
        end
    end

    // Command register; a write with start set launches one operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd     <= psau_pkg::RST_WORD;
            exec_go <= 1'b0;
        end else begin
            exec_go <= bus_wr && (paddr == psau_pkg::OFS_CMD) && pwdata[31];
            if (bus_wr && (paddr == psau_pkg::OFS_CMD)) begin
                cmd <= {1'b0, 8'h0, pwdata[22:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Operand fetch and decode
    // ------------------------------------------------------------
    assign dst_op = preg[cmd.dst];
    assign src_op = cmd.src_mem ? mem_data : preg[cmd.src];

    // Opcode decode
    always_comb begin
        if (cmd.opcode == psau_pkg::OPC_SB) begin
            op = psau_pkg::OP_SB;
        end else if (cmd.opcode == psau_pkg::OPC_SW) begin
            op = psau_pkg::OP_SW;
        end else if (cmd.opcode == psau_pkg::OPC_UB) begin
            op = psau_pkg::OP_UB;
        end else if (cmd.opcode == psau_pkg::OPC_UW) begin
            op = psau_pkg::OP_UW;
        end else if (cmd.opcode == psau_pkg::OPC_AND) begin
            op = psau_pkg::OP_AND;
        end else begin
            op = psau_pkg::OP_NONE;
        end
    end

    // ------------------------------------------------------------
    // Lane arithmetic
    // ------------------------------------------------------------
    genvar gi;
    generate
        // Eight byte lanes, each with its own 9-bit sum
        for (gi = 0; gi < 8; gi++) begin : g_byte
            logic [8:0] ssum;
            logic [8:0] usum;
            assign ssum = {dst_op[8*gi+7], dst_op[8*gi +: 8]}
                        + {src_op[8*gi+7], src_op[8*gi +: 8]};
            assign usum = {1'b0, dst_op[8*gi +: 8]} + {1'b0, src_op[8*gi +: 8]};
            // Sign of the 9-bit sum tells overflow from underflow
            assign sb_res[8*gi +: 8] = (ssum[8] == ssum[7]) ? ssum[7:0]
                                     : (ssum[8] ? psau_pkg::SB_MIN
                                                : psau_pkg::SB_MAX);
            // Adding unsigned values cannot fall below zero
            assign ub_res[8*gi +: 8] = usum[8] ? psau_pkg::UB_MAX : usum[7:0];
        end
        // Four word lanes, saturated one by one
        for (gi = 0; gi < 4; gi++) begin : g_word
            logic [16:0] ssum;
            logic [16:0] usum;
            assign ssum = {dst_op[16*gi+15], dst_op[16*gi +: 16]}
                        + {src_op[16*gi+15], src_op[16*gi +: 16]};
            assign usum = {1'b0, dst_op[16*gi +: 16]} + {1'b0, src_op[16*gi +: 16]};
            assign sw_res[16*gi +: 16] = (ssum[16] == ssum[15]) ? ssum[15:0]
                                       : (ssum[16] ? psau_pkg::SW_MIN
                                                   : psau_pkg::SW_MAX);
            assign uw_res[16*gi +: 16] = usum[16] ? psau_pkg::UW_MAX
                                                  : usum[15:0];
        end
    endgenerate

    // Result select by operation
    always_comb begin
        case (op)
            psau_pkg::OP_SB:  result = sb_res;
            psau_pkg::OP_SW:  result = sw_res;
            psau_pkg::OP_UB:  result = ub_res;
            psau_pkg::OP_UW:  result = uw_res;
            psau_pkg::OP_AND: result = dst_op & src_op;
            default:          result = dst_op;
        endcase
    end

    // ------------------------------------------------------------
    // Fault detection
    // ------------------------------------------------------------
    assign addr_end = {1'b0, mem_addr} + psau_pkg::OPND_LAST;

    // Faults in priority order; memory faults only for a memory source
    always_comb begin
        next_fault = psau_pkg::RST_WORD;
        next_fault.invalid_opcode_fault = ctrl.emulation_control_bit
                                       || (op == psau_pkg::OP_NONE);
        next_fault.device_not_available_fault = !next_fault.invalid_opcode_fault
                                             && ctrl.task_switched_bit;
        next_fault.math_fault = !next_fault.invalid_opcode_fault
                             && !next_fault.device_not_available_fault
                             && ctrl.fpu_pending;
        if (cmd.src_mem && !next_fault.invalid_opcode_fault
            && !next_fault.device_not_available_fault && !next_fault.math_fault) begin
            if (ctrl.prot_mode) begin
                if (memchk.seg_bad) begin
                    next_fault.general_protection_fault = 1'b1;
                    next_fault.code = psau_pkg::GP_CODE;
                end else if (memchk.stack_bad) begin
                    next_fault.stack_fault = 1'b1;
                end else if (memchk.page_miss) begin
                    next_fault.page_fault = 1'b1;
                    next_fault.code = memchk.pf_code;
                end else if ((mem_addr[2:0] != 3'h0) && (ctrl.cpl == psau_pkg::CPL_USER)) begin
                    next_fault.alignment_check_fault = 1'b1;
                end
            end else if (addr_end > psau_pkg::REAL_LIMIT) begin
                next_fault.real_range = 1'b1;
            end
        end
        any_fault = next_fault[8:1] != 8'h0;
        next_fault.committed = !any_fault;
    end

    // Fault status of the last launched operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault <= psau_pkg::RST_WORD;
        end else if (exec_go) begin
            fault <= next_fault;
        end
    end

    // ------------------------------------------------------------
    // Packed register file
    // ------------------------------------------------------------

    // Only the destination changes; no flag state exists here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < psau_pkg::NUM_PREGS; i++) begin
                preg[i] <= psau_pkg::RST_PREG;
            end
        end else begin
            if (bus_wr && (paddr[7:6] == psau_pkg::FILE_PAGE)) begin
                if (paddr[psau_pkg::FILE_HALF_BIT]) begin
                    preg[file_idx][63:32] <= pwdata;
                end else begin
                    preg[file_idx][31:0] <= pwdata;
                end
            end
            if (exec_go && !any_fault) begin
                preg[cmd.dst] <= result;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_run(psau_pkg::psau_op_t k);
        exec_go && !any_fault && (op == k);
    endsequence

    sequence seq_fault;
        exec_go && any_fault;
    endsequence

    a_ud_emulation: assert property (exec_go && ctrl.emulation_control_bit
        |=> fault.invalid_opcode_fault && !fault.committed)
        else $error("emulation bit did not give invalid opcode");
    a_nm_task_sw: assert property (exec_go && !ctrl.emulation_control_bit
        && op != psau_pkg::OP_NONE && ctrl.task_switched_bit
        |=> fault.device_not_available_fault)
        else $error("task switched bit did not give device fault");
    a_keep_on_fault: assert property (seq_fault
        |=> preg[$past(cmd.dst)] == $past(dst_op))
        else $error("destination changed despite a fault");
    a_and_exact: assert property (seq_run(psau_pkg::OP_AND)
        |=> preg[$past(cmd.dst)] == ($past(dst_op) & $past(src_op)))
        else $error("logical form result wrong");
    a_sb_clamp_hi: assert property (seq_run(psau_pkg::OP_SB)
        ##0 (!dst_op[7] && !src_op[7] && (dst_op[7:0] + src_op[7:0] > 8'h7f))
        |=> preg[$past(cmd.dst)][7:0] == 8'h7f)
        else $error("signed byte overflow not clamped");

    a_sw_clamp_lo: assert property (seq_run(psau_pkg::OP_SW)
        ##0 (dst_op[15] && src_op[15] && (17'(dst_op[15:0]) + 17'(src_op[15:0]) < 17'h18000))
        |=> preg[$past(cmd.dst)][15:0] == 16'h8000)
        else $error("signed word underflow not clamped");

    a_ub_clamp: assert property (seq_run(psau_pkg::OP_UB)
        ##0 (9'(dst_op[7:0]) + 9'(src_op[7:0]) > 9'h0ff)
        |=> preg[$past(cmd.dst)][7:0] == 8'hff)
        else $error("unsigned byte overflow not clamped");

    a_uw_clamp: assert property (seq_run(psau_pkg::OP_UW)
        ##0 (17'(dst_op[63:48]) + 17'(src_op[63:48]) > 17'h0ffff)
        |=> preg[$past(cmd.dst)][63:48] == 16'hffff)
        else $error("unsigned word overflow not clamped");

    a_lane_no_carry: assert property (seq_run(psau_pkg::OP_UB)
        ##0 (dst_op[15:8] == 8'h00 && src_op[15:8] == 8'h00)
        |=> preg[$past(cmd.dst)][15:8] == 8'h00)
        else $error("carry crossed a byte lane");

    a_int13_range: assert property (exec_go && !ctrl.prot_mode && cmd.src_mem
        && next_fault[3:1] == 3'h0 && !ctrl.emulation_control_bit
        && mem_addr > 32'h0000_fff8
        |=> fault.real_range ##1 !fault.committed)
        else $error("real mode range fault missed");

    a_ac_user: assert property (exec_go && ctrl.prot_mode && cmd.src_mem
        && ctrl.cpl == 2'h3 && mem_addr[2:0] != 3'h0 && memchk[2:0] == 3'h0
        && next_fault[3:1] == 3'h0
        |=> fault.alignment_check_fault)
        else $error("alignment fault missed at privilege 3");

    a_gp_code0: assert property (exec_go && ctrl.prot_mode && cmd.src_mem
        && memchk.seg_bad && next_fault[3:1] == 3'h0
        |=> fault.general_protection_fault && fault.code == 16'h0000)
        else $error("general protection fault or code wrong");

endmodule
